// ---- pmsc_pkg.sv ----
// Package: register map, field positions, reset values and carriers
package pmsc_pkg;

  localparam int          ADDR_W            = 8;
  localparam int          REG_W             = 8;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0]  OFS_CTRL_STATUS_1 = 8'h00;
  localparam logic [7:0]  OFS_CTRL_STATUS_2 = 8'h04;
  localparam logic [7:0]  OFS_CTRL_STATUS_3 = 8'h08;

  // Fields of power_mgmt_ctrl_status_1
  localparam int          BIT_DET_FLAG      = 7;
  localparam int          BIT_DET_ACK       = 6;
  localparam int          BIT_DET_IRQ_EN    = 5;
  localparam int          BIT_DET_RESET_EN  = 4;
  localparam int          BIT_DET_STOP_EN   = 3;
  localparam int          BIT_DET_EN        = 2;
  localparam int          BIT_BANDGAP_EN    = 0;

  // Fields of power_mgmt_ctrl_status_2
  localparam int          BIT_FULL_PD_REC   = 4;
  localparam int          BIT_PART_PD_REC   = 3;
  localparam int          BIT_PD_ACK        = 2;
  localparam int          BIT_PD_ALLOW      = 1;
  localparam int          BIT_PD_MODE_SEL   = 0;

  // Fields of power_mgmt_ctrl_status_3
  localparam int          BIT_WARN_FLAG     = 7;
  localparam int          BIT_WARN_ACK      = 6;
  localparam int          BIT_DET_TRIP      = 5;
  localparam int          BIT_WARN_TRIP     = 4;

  // Write-once bits, index into the write-once bank
  localparam int          WO_DET_EN         = 0;
  localparam int          WO_DET_RESET_EN   = 1;
  localparam int          WO_PD_ALLOW       = 2;
  localparam int          WO_COUNT          = 3;

  // Values after reset
  localparam logic [2:0]  RST_WRITE_ONCE    = 3'h3;
  localparam logic        RST_DET_IRQ_EN    = 1'b0;
  localparam logic        RST_DET_STOP_EN   = 1'b1;
  localparam logic        RST_BANDGAP_EN    = 1'b0;
  localparam logic        RST_PD_MODE_SEL   = 1'b0;
  localparam logic        RST_DET_TRIP      = 1'b0;
  localparam logic        RST_WARN_TRIP     = 1'b0;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef struct packed {
    logic below_detect;
    logic below_warning;
  } supply_ind_t;

  typedef struct packed {
    logic full_recovered;
    logic partial_recovered;
  } pd_event_t;

  typedef struct packed {
    logic bandgap_buffer_en;
    logic detect_trip_select;
    logic warning_trip_select;
    logic detect_monitor_en;
  } monitor_cfg_t;

  typedef struct packed {
    logic powerdown_allow;
    logic powerdown_mode_select;
  } stop_cfg_t;

endpackage : pmsc_pkg

// ---- power_mgmt_status_control.sv ----
// Supply monitor status and stop-mode control behind an AXI4-Lite slave
// Functional notes
// R1 - Detect flag, bit 7 of register 1, sets on detect event while enabled
// R2 - Writing 1 to detect ack bit 6 clears the flag; it reads 0
// R3 - Interrupt enable bit 5 raises interrupt request while the detect flag is set
// R4 - Write-once reset enable bit 4 forces chip reset when flag sets and enabled
// R5 - Stop enable bit 3 keeps detection running in stop mode
// R6 - Write-once detect enable bit 2 switches detect logic and gates other bits
// R7 - Bit 0 of register 1 drives the bandgap buffer enable
// R8 - Software writes 0 to reserved bit 1 of register 1
// R9 - Write-once bits take the first write after reset only
// R10 - Register 2 bit 4 reads 1 after recovery from full power-down
// R11 - Register 2 bit 3 reads 1 after recovery from partial power-down
// R12 - Writing 1 to register 2 bit 2 clears both recovery flags
// R13 - Power-down allow bit 1 permits power-down stop modes when 1
// R14 - Mode select bit 0 picks full (0) or partial (1) power-down
// R15 - Warning flag, register 3 bit 7, is sticky
// R16 - Warning ack bit 6 clears the flag only when warning is gone
// R17 - Register 3 bit 5 selects the detect trip level
// R18 - Register 3 bit 4 selects the warning trip level
// R19 - Warning flag sets on warning indication, also right after reset
// R20 - Software checks partial flag, restores I/O, then acks before pin access
// R21 - Comparator indications are registered on the bus clock before flags use them
`timescale 1ns/100ps
module power_mgmt_status_control
  import pmsc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire supply_ind_t       supply_in,
  input  wire logic              stop_mode,
  input  wire pd_event_t         pd_event,
  output monitor_cfg_t           monitor_cfg,
  output stop_cfg_t              stop_cfg,
  output logic                   low_volt_detect_irq,
  output logic                   chip_reset_req
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    reg_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : reg_hit
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = reg_hit(a, OFS_CTRL_STATUS_1) | reg_hit(a, OFS_CTRL_STATUS_2)
               | reg_hit(a, OFS_CTRL_STATUS_3);
  endfunction : reg_mapped
  logic              aw_got_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic              w_got_ff;
  logic [REG_W-1:0]  wdata_ff;
  logic              wlane0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              do_write;
  logic              wr1;
  logic              wr2;
  logic              wr3;
  logic [REG_W-1:0]  rd_value;

  supply_ind_t       supply_q_ff;
  logic              irq_en_ff;
  logic              stop_en_ff;
  logic              bandgap_ff;
  logic              mode_sel_ff;
  logic              det_trip_ff;
  logic              warn_trip_ff;
  logic              irq_ff;
  logic              reset_req_ff;
  logic [WO_COUNT-1:0] wo_q;
  logic [WO_COUNT-1:0] wo_locked;
  logic [WO_COUNT-1:0] wo_wr_en;
  logic [WO_COUNT-1:0] wo_wr_data;
  logic              det_en;
  logic              det_active;
  logic              det_set;
  logic              det_flag;
  logic              warn_flag;
  logic              full_rec;
  logic              part_rec;
  logic              pd_ack;

  // Write channel: address and data taken in either order
  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_got_ff & ~bvalid_ff;
  assign do_write      = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr1 = do_write & wlane0_ff & reg_hit(waddr_ff, OFS_CTRL_STATUS_1);
  assign wr2 = do_write & wlane0_ff & reg_hit(waddr_ff, OFS_CTRL_STATUS_2);
  assign wr3 = do_write & wlane0_ff & reg_hit(waddr_ff, OFS_CTRL_STATUS_3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      waddr_ff  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      waddr_ff  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff  <= 1'b0;
      wdata_ff  <= '0;
      wlane0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff  <= 1'b1;
      wdata_ff  <= s_axi_wdata[REG_W-1:0];
      wlane0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_got_ff  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= reg_mapped(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // Read channel: one outstanding read, data latched at address accept
  assign s_axi_arready = ~rvalid_ff;

  always_comb begin
    rd_value = '0;
    if (reg_hit(s_axi_araddr, OFS_CTRL_STATUS_1)) begin
      rd_value[BIT_DET_FLAG]     = det_flag & det_en; // R1
      rd_value[BIT_DET_ACK]      = 1'b0; // R2
      rd_value[BIT_DET_IRQ_EN]   = irq_en_ff;
      rd_value[BIT_DET_RESET_EN] = wo_q[WO_DET_RESET_EN];
      rd_value[BIT_DET_STOP_EN]  = stop_en_ff;
      rd_value[BIT_DET_EN]       = det_en;
      rd_value[BIT_BANDGAP_EN]   = bandgap_ff;
    end else if (reg_hit(s_axi_araddr, OFS_CTRL_STATUS_2)) begin
      rd_value[BIT_FULL_PD_REC]  = full_rec; // R10
      rd_value[BIT_PART_PD_REC]  = part_rec; // R11
      rd_value[BIT_PD_ALLOW]     = wo_q[WO_PD_ALLOW];
      rd_value[BIT_PD_MODE_SEL]  = mode_sel_ff;
    end else if (reg_hit(s_axi_araddr, OFS_CTRL_STATUS_3)) begin
      rd_value[BIT_WARN_FLAG]    = warn_flag; // R15
      rd_value[BIT_DET_TRIP]     = det_trip_ff;
      rd_value[BIT_WARN_TRIP]    = warn_trip_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {{(32 - REG_W){1'b0}}, rd_value};
      rresp_ff  <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // Comparator outputs are held one cycle so every flag sees the same sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_q_ff <= '0;
    end else begin
      supply_q_ff <= supply_in; // R21
    end
  end

  // Reserved bit 1 of register 1 is not stored, so a stray 1 has no effect
  assign wo_wr_en[WO_DET_EN]         = wr1; // R9
  assign wo_wr_en[WO_DET_RESET_EN]   = wr1;
  assign wo_wr_en[WO_PD_ALLOW]       = wr2;
  assign wo_wr_data[WO_DET_EN]       = wdata_ff[BIT_DET_EN];
  assign wo_wr_data[WO_DET_RESET_EN] = wdata_ff[BIT_DET_RESET_EN];
  assign wo_wr_data[WO_PD_ALLOW]     = wdata_ff[BIT_PD_ALLOW];

  write_once_bits #(
    .WIDTH     (WO_COUNT),
    .RESET_VAL (RST_WRITE_ONCE)
  ) u_write_once (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_en     (wo_wr_en),
    .wr_data   (wo_wr_data),
    .q_ff      (wo_q),
    .locked_ff (wo_locked)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_ff  <= RST_DET_IRQ_EN;
      stop_en_ff <= RST_DET_STOP_EN;
      bandgap_ff <= RST_BANDGAP_EN;
    end else if (wr1) begin
      irq_en_ff  <= wdata_ff[BIT_DET_IRQ_EN];
      stop_en_ff <= wdata_ff[BIT_DET_STOP_EN];
      bandgap_ff <= wdata_ff[BIT_BANDGAP_EN]; // R7
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_sel_ff <= RST_PD_MODE_SEL;
    end else if (wr2) begin
      mode_sel_ff <= wdata_ff[BIT_PD_MODE_SEL]; // R14
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_trip_ff  <= RST_DET_TRIP;
      warn_trip_ff <= RST_WARN_TRIP;
    end else if (wr3) begin
      det_trip_ff  <= wdata_ff[BIT_DET_TRIP]; // R17
      warn_trip_ff <= wdata_ff[BIT_WARN_TRIP]; // R18
    end
  end

  // Detection runs only when enabled, and in stop only with stop enable
  assign det_en     = wo_q[WO_DET_EN]; // R6
  assign det_active = det_en & (~stop_mode | stop_en_ff); // R5
  assign det_set    = supply_q_ff.below_detect & det_active; // R1

  sticky_flag u_det_flag (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (det_set),
    .clr     ((wr1 & wdata_ff[BIT_DET_ACK]) | ~det_en), // R2
    .q_ff    (det_flag)
  );
  sticky_flag u_warn_flag (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (supply_q_ff.below_warning), // R19
    .clr     (wr3 & wdata_ff[BIT_WARN_ACK] & ~supply_q_ff.below_warning), // R16
    .q_ff    (warn_flag)
  );
  assign pd_ack = wr2 & wdata_ff[BIT_PD_ACK]; // R12
  sticky_flag u_full_rec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (pd_event.full_recovered), // R10
    .clr     (pd_ack),
    .q_ff    (full_rec)
  );
  sticky_flag u_part_rec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (pd_event.partial_recovered), // R11
    .clr     (pd_ack),
    .q_ff    (part_rec)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff       <= 1'b0;
      reset_req_ff <= 1'b0;
    end else begin
      irq_ff       <= det_flag & irq_en_ff & det_en; // R3
      reset_req_ff <= det_flag & wo_q[WO_DET_RESET_EN] & det_en; // R4
    end
  end

  assign low_volt_detect_irq               = irq_ff;
  assign chip_reset_req                    = reset_req_ff;
  assign monitor_cfg.bandgap_buffer_en     = bandgap_ff;
  assign monitor_cfg.detect_trip_select    = det_trip_ff;
  assign monitor_cfg.warning_trip_select   = warn_trip_ff;
  assign monitor_cfg.detect_monitor_en     = det_active;
  assign stop_cfg.powerdown_allow          = wo_q[WO_PD_ALLOW]; // R13
  assign stop_cfg.powerdown_mode_select    = mode_sel_ff;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Activity counts in the cycle the registered sample is used, not when it arrives
  property p_detect_sets; supply_in.below_detect ##1 det_active |=> det_flag; endproperty
  a_detect_sets: assert property (p_detect_sets) else $error("detect flag missed"); // R1
  property p_detect_ack; wr1 && wdata_ff[BIT_DET_ACK] && !det_set |=> !det_flag; endproperty
  a_detect_ack: assert property (p_detect_ack) else $error("detect ack ignored"); // R2
  property p_ack_reads_zero;
    s_axi_arvalid && s_axi_arready |=> !s_axi_rdata[BIT_DET_ACK];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read 1"); // R2
  property p_irq; det_flag && irq_en_ff && det_en |=> low_volt_detect_irq; endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // R3
  property p_no_irq; !irq_en_ff |=> !low_volt_detect_irq; endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt while disabled"); // R3
  property p_reset_req; det_flag && wo_q[WO_DET_RESET_EN] && det_en |=> chip_reset_req; endproperty
  a_reset_req: assert property (p_reset_req) else $error("chip reset not forced"); // R4
  property p_stop_off; stop_mode && !stop_en_ff |-> !monitor_cfg.detect_monitor_en; endproperty
  a_stop_off: assert property (p_stop_off) else $error("detect active in stop"); // R5
  property p_disabled_clears; !det_en |=> !det_flag && !chip_reset_req; endproperty
  a_disabled_clears: assert property (p_disabled_clears) else $error("flag while off"); // R6
  property p_bandgap;
    wr1 |=> monitor_cfg.bandgap_buffer_en == $past(wdata_ff[BIT_BANDGAP_EN]);
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap enable not written"); // R7
  property p_write_once;
    wr1 && wo_locked[WO_DET_EN] |=> $stable(det_en) && $stable(wo_q[WO_DET_RESET_EN]);
  endproperty
  a_write_once: assert property (p_write_once) else $error("write-once bit changed"); // R9
  property p_recovery_set;
    pd_event.full_recovered && pd_event.partial_recovered |=> full_rec && part_rec;
  endproperty
  a_recovery_set: assert property (p_recovery_set) else $error("recovery flag missed"); // R10
  property p_partial_set; pd_event.partial_recovered |=> part_rec; endproperty
  a_partial_set: assert property (p_partial_set) else $error("partial flag missed"); // R11
  property p_pd_ack;
    pd_ack && !pd_event.full_recovered && !pd_event.partial_recovered |=> !full_rec && !part_rec;
  endproperty
  a_pd_ack: assert property (p_pd_ack) else $error("recovery ack ignored"); // R12
  property p_pd_ctrl;
    wr2 && !wo_locked[WO_PD_ALLOW] |=> stop_cfg.powerdown_allow == $past(wdata_ff[BIT_PD_ALLOW])
      && stop_cfg.powerdown_mode_select == $past(wdata_ff[BIT_PD_MODE_SEL]);
  endproperty
  a_pd_ctrl: assert property (p_pd_ctrl) else $error("power-down control not written"); // R13
  property p_warn_sticky; warn_flag && !wr3 |=> warn_flag; endproperty
  a_warn_sticky: assert property (p_warn_sticky) else $error("warning flag dropped"); // R15
  property p_warn_blocked; supply_q_ff.below_warning |=> warn_flag; endproperty
  a_warn_blocked: assert property (p_warn_blocked) else $error("warning cleared while present"); // R16
  property p_warn_ack;
    wr3 && wdata_ff[BIT_WARN_ACK] && !supply_q_ff.below_warning |=> !warn_flag;
  endproperty
  a_warn_ack: assert property (p_warn_ack) else $error("warning ack ignored"); // R16
  property p_trip;
    wr3 |=> monitor_cfg.detect_trip_select == $past(wdata_ff[BIT_DET_TRIP])
      && monitor_cfg.warning_trip_select == $past(wdata_ff[BIT_WARN_TRIP]);
  endproperty
  a_trip: assert property (p_trip) else $error("trip select not written"); // R17
  property p_warn_input; supply_in.below_warning |=> ##1 warn_flag; endproperty
  a_warn_input: assert property (p_warn_input) else $error("warning not set in 2 cycles"); // R21
  property p_bresp; do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready; endproperty
  a_bresp: assert property (p_bresp) else $error("write response missing");

endmodule : power_mgmt_status_control

// ---- sticky_flag.sv ----
// Status flag set by hardware, cleared by software, set wins
`timescale 1ns/100ps
module sticky_flag (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      q_ff
);

  logic nxt_q;

  // Set beats clear so an event in the clear cycle is kept
  always_comb begin
    nxt_q = set | (q_ff & ~clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule : sticky_flag

// ---- tb_power_mgmt_status_control.sv ----
// Self-checking testbench for the power management status and control block
`timescale 1ns/100ps
module tb_power_mgmt_status_control
  import pmsc_pkg::*;
;
  logic              aclk;
  logic              aresetn;
  logic [ADDR_W-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [ADDR_W-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  supply_ind_t       supply_in;
  logic              stop_mode;
  pd_event_t         pd_event;
  monitor_cfg_t      monitor_cfg;
  stop_cfg_t         stop_cfg;
  logic              irq;
  logic              rst_req;
  int                bad_count;
  int                checks;
  logic [31:0]       rd_d;
  logic [1:0]        rd_r;
  logic [1:0]        wr_r;

  power_mgmt_status_control i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .supply_in(supply_in), .stop_mode(stop_mode),
    .pd_event(pd_event), .monitor_cfg(monitor_cfg), .stop_cfg(stop_cfg),
    .low_volt_detect_irq(irq), .chip_reset_req(rst_req)
  );

  always #2.5 aclk = ~aclk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wrap_up;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task do_reset;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  // Ready is sampled just after an edge; inputs only move on edges
  task wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    ha = 1'b0;
    hw = 1'b0;
    while (!(ha && hw)) begin
      #1;
      if (awvalid && awready) ha = 1'b1;
      if (wvalid && wready) hw = 1'b1;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    hb = 1'b0;
    while (!hb) begin
      #1;
      hb = bvalid;
      r  = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hs;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    hs = 1'b0;
    while (!hs) begin
      #1;
      hs = arvalid && arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    hs = 1'b0;
    while (!hs) begin
      #1;
      hs = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask : rd

  task w1(input logic [7:0] a, input logic [7:0] d);
    wr(a, d, wr_r);
    chk(32'(wr_r), 32'(RESP_OKAY));
  endtask : w1

  task r1(input logic [7:0] a, input logic [7:0] e);
    rd(a, rd_d, rd_r);
    chk(rd_d, {24'h0, e});
    chk(32'(rd_r), 32'(RESP_OKAY));
  endtask : r1

  task settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle

  initial begin
    aclk = 1'b0; aresetn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0;
    wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
    supply_in = '0; stop_mode = 1'b0; pd_event = '0; bad_count = 0; checks = 0;
    do_reset();
    r1(OFS_CTRL_STATUS_1, 8'h1C);
    r1(OFS_CTRL_STATUS_2, 8'h00);
    r1(OFS_CTRL_STATUS_3, 8'h00);
    chk(32'(monitor_cfg), 32'h1);
    chk(32'({irq, rst_req}), 32'h0);
    $display("test reset_values done");
    // Reserved bit 1 always written as zero
    w1(OFS_CTRL_STATUS_1, 8'h01);
    r1(OFS_CTRL_STATUS_1, 8'h01);
    w1(OFS_CTRL_STATUS_1, 8'h3D);
    supply_in.below_detect <= 1'b1;
    settle(4);
    r1(OFS_CTRL_STATUS_1, 8'h29);
    chk(32'(monitor_cfg), 32'h8);
    chk(32'({irq, rst_req}), 32'h0);
    supply_in.below_detect <= 1'b0;
    $display("test write_once done");
    do_reset();
    w1(OFS_CTRL_STATUS_1, 8'h24);
    stop_mode <= 1'b1;
    settle(1);
    chk(32'(monitor_cfg), 32'h0);
    @(posedge aclk);
    stop_mode <= 1'b0;
    supply_in.below_detect <= 1'b1;
    settle(4);
    chk(32'({irq, rst_req}), 32'h2);
    r1(OFS_CTRL_STATUS_1, 8'hA4);
    w1(OFS_CTRL_STATUS_1, 8'h64);
    r1(OFS_CTRL_STATUS_1, 8'hA4);
    supply_in.below_detect <= 1'b0;
    w1(OFS_CTRL_STATUS_1, 8'h64);
    settle(2);
    r1(OFS_CTRL_STATUS_1, 8'h24);
    chk(32'(irq), 32'h0);
    w1(OFS_CTRL_STATUS_1, 8'h04);
    supply_in.below_detect <= 1'b1;
    settle(4);
    r1(OFS_CTRL_STATUS_1, 8'h84);
    chk(32'({irq, rst_req}), 32'h0);
    supply_in.below_detect <= 1'b0;
    $display("test detect_flag done");
    do_reset();
    supply_in.below_detect <= 1'b1;
    settle(4);
    chk(32'(rst_req), 32'h1);
    @(posedge aclk);
    supply_in.below_detect <= 1'b0;
    pd_event.full_recovered <= 1'b1;
    @(posedge aclk);
    pd_event.full_recovered <= 1'b0;
    r1(OFS_CTRL_STATUS_2, 8'h10);
    pd_event.partial_recovered <= 1'b1;
    @(posedge aclk);
    pd_event.partial_recovered <= 1'b0;
    r1(OFS_CTRL_STATUS_2, 8'h18);
    w1(OFS_CTRL_STATUS_2, 8'h07);
    r1(OFS_CTRL_STATUS_2, 8'h03);
    chk(32'(stop_cfg), 32'h3);
    // Power-down allow is locked at 1, so clearing it must not stick
    w1(OFS_CTRL_STATUS_2, 8'h00);
    r1(OFS_CTRL_STATUS_2, 8'h02);
    chk(32'(stop_cfg), 32'h2);
    $display("test powerdown done");
    w1(OFS_CTRL_STATUS_3, 8'h30);
    r1(OFS_CTRL_STATUS_3, 8'h30);
    chk(32'(monitor_cfg), 32'h7);
    supply_in.below_warning <= 1'b1;
    settle(4);
    r1(OFS_CTRL_STATUS_3, 8'hB0);
    w1(OFS_CTRL_STATUS_3, 8'h70);
    r1(OFS_CTRL_STATUS_3, 8'hB0);
    supply_in.below_warning <= 1'b0;
    settle(4);
    r1(OFS_CTRL_STATUS_3, 8'hB0);
    w1(OFS_CTRL_STATUS_3, 8'h70);
    r1(OFS_CTRL_STATUS_3, 8'h30);
    wr(8'h0C, 8'hFF, wr_r);
    chk(32'(wr_r), 32'(RESP_SLVERR));
    rd(8'h0C, rd_d, rd_r);
    chk(32'(rd_r), 32'(RESP_SLVERR));
    $display("test warning_and_map done");
    // Warning already present while reset is released
    supply_in.below_warning <= 1'b1;
    do_reset();
    settle(3);
    @(posedge aclk);
    supply_in.below_warning <= 1'b0;
    r1(OFS_CTRL_STATUS_3, 8'h80);
    $display("test warning_at_reset done");
    wrap_up();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    wrap_up();
  end
endmodule : tb_power_mgmt_status_control

// ---- write_once_bits.sv ----
// Bank of bits that accept only the first write after reset
`timescale 1ns/100ps
module write_once_bits #(
  parameter int               WIDTH     = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] q_ff,
  output logic      [WIDTH-1:0] locked_ff
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff      <= RESET_VAL;
      locked_ff <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        // Later writes are dropped silently
        if (wr_en[i] && !locked_ff[i]) begin
          q_ff[i]      <= wr_data[i];
          locked_ff[i] <= 1'b1;
        end
      end
    end
  end

endmodule : write_once_bits
